// >>> eeh_host.v
// Two-wire EEPROM host controller with an APB register port.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
`include "eeh_defines.vh"
// Summary of operation
// RULE1: Data line changes only while the serial clock is low.
// RULE2: A falling data line with clock high starts every command.
// RULE3: A rising data line with clock high stops the transfer.
// RULE4: Words are eight bits; the receiver acknowledges low on the ninth clock.
// RULE5: Device samples on rising clock and drives on falling clock.
// RULE6: Device enters standby at power-up and after stop once idle.
// RULE7: Recovery gives nine clocks with data high, then a start.
// RULE8: A device address word follows every start condition; the recovery start is followed directly by a stop instead.
// RULE9: Three select bits are matched against the device strap pins.
// RULE10: Last address bit high means read, low means write.
// RULE11: Device acknowledges a matching address, otherwise goes to standby.
// RULE12: Byte write sends address, two address bytes, one data byte, stop.
// RULE13: After a write stop the device programs for up to 3 ms.
// RULE14: Main array is 128 pages of 32 bytes, 12-bit byte address.
// RULE15: Page write sends up to 32 data bytes, then stop.
// RULE16: Only the low five address bits advance during a page write.
// RULE17: Write-protect pin high blocks writes to the whole array.
// RULE18: ID page write uses type 1011 with the lock select bit zero.
// RULE19: A locked ID page refuses acknowledge for its data bytes.
// RULE20: Polling repeats start and address until the device acknowledges.
// RULE21: ID lock uses type 1011, lock select bit one, data bit 1 set.
// RULE22: Read address wraps from the last byte to the first.
// RULE23: Sequential read continues while the host acknowledges each byte.
// RULE24: ID page read uses random-read format with type 1011.
// RULE25: Main array device type code is 1010.
// RULE26: Protected writes are acknowledged but start no programming cycle.
module eeh_host #(
    parameter QUARTER_CYC = `EEH_QUARTER_CYC,
    parameter PROG_CYCLES = `EEH_PROG_CYCLES
) (
    input wire i_clock, // System clock, 100 MHz.
    input wire i_nrst, // Synchronous reset, active low.
    input wire i_psel, // APB select.
    input wire i_penable, // APB enable.
    input wire i_pwrite, // APB write direction.
    input wire [7:0] i_paddr, // APB byte address.
    input wire [31:0] i_pwdata, // APB write data.
    output reg [31:0] o_prdata, // APB read data.
    output wire o_pready, // APB ready.
    output wire o_pslverr, // APB error on unmapped address.
    output reg o_scl, // Serial clock to the device.
    input wire i_sda, // Serial data line level.
    output wire o_sda, // Serial data drive value, always low.
    output wire o_sda_oe_n, // Data drive enable, low while pulling low.
    output reg o_wp, // Write-protect pin drive.
    output wire o_busy // Command in progress.
);
    localparam ST_IDLE = 3'h0;
    localparam ST_NEXT = 3'h1;
    localparam ST_START = 3'h2;
    localparam ST_BIT = 3'h3;
    localparam ST_STOP = 3'h4;
    localparam ST_CLK = 3'h5;
    localparam SQ_DEV = 4'h0;
    localparam SQ_AH = 4'h1;
    localparam SQ_AL = 4'h2;
    localparam SQ_DATA = 4'h3;
    localparam SQ_RSTART = 4'h4;
    localparam SQ_DEVR = 4'h5;
    localparam SQ_RD = 4'h6;
    localparam SQ_STOP = 4'h7;
    localparam SQ_PSTART = 4'h8;
    localparam SQ_PDEV = 4'h9;
    localparam SQ_PEND = 4'hA;
    localparam SQ_PSTOP = 4'hB;
    localparam SQ_DONE = 4'hC;
    localparam SQ_RST = 4'hD;

    reg [2:0] state_r;
    reg [3:0] step_r;
    reg [1:0] q_r;
    reg [3:0] bit_r;
    reg [7:0] sh_r;
    reg rx_r;
    reg ack_send_r;
    reg ack_bit_r;
    reg sda_low_r;
    reg [5:0] cnt_r;
    reg [5:0] len_r;
    reg [2:0] op_r;
    reg [15:0] addr_r;
    reg [2:0] straps_r;
    reg done_r;
    reg nack_r;
    reg timeout_r;
    reg poll_r;
    reg [`EEH_TMR_W-1:0] tmr_r;
    reg [7:0] buf_r [0:31];
    wire tick;
    wire sda_s;
    wire [5:0] len_req;
    wire is_id;
    wire is_wr;
    wire last;
    wire tmr_done;
    wire [7:0] dev_w;
    wire [7:0] addr_hi;
    wire bus_wr;
    wire go;
    wire mapped;

    eeh_tick #(.DIV(QUARTER_CYC)) u_tick (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .o_tick(tick)
    );

    eeh_sync #(.W(1)) u_sda_sync (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_d(i_sda),
        .o_q(sda_s)
    );

    assign o_sda = 1'b0;
    assign o_sda_oe_n = ~sda_low_r;
    assign o_busy = (state_r != ST_IDLE);
    assign is_id = (op_r == `EEH_OP_ID_WRITE) || (op_r == `EEH_OP_ID_READ) || (op_r == `EEH_OP_ID_LOCK);
    assign is_wr = (op_r == `EEH_OP_WRITE) || (op_r == `EEH_OP_ID_WRITE) || (op_r == `EEH_OP_ID_LOCK);
    assign last = (cnt_r == len_r - 6'h01);
    assign tmr_done = (tmr_r >= PROG_CYCLES[`EEH_TMR_W-1:0]);
    // Type code, strap match and write direction of the address word.
    assign dev_w = {(is_id ? `EEH_TYPE_ID : `EEH_TYPE_MAIN), straps_r, 1'b0}; // RULE9 RULE10 RULE25 RULE18
    // The lock select bit is forced so a page write can never lock by accident.
    assign addr_hi = (op_r == `EEH_OP_ID_WRITE) ? (addr_r[15:8] & ~(8'h01 << `EEH_IDLOCK_SEL_BIT)) : // RULE18
                     (op_r == `EEH_OP_ID_LOCK) ? (addr_r[15:8] | (8'h01 << `EEH_IDLOCK_SEL_BIT)) : // RULE21
                     addr_r[15:8];

    assign bus_wr = i_psel && i_penable && i_pwrite;
    assign go = bus_wr && (i_paddr == `EEH_REG_CTRL) && i_pwdata[`EEH_CTRL_GO] && (state_r == ST_IDLE);
    assign len_req = i_pwdata[`EEH_CTRL_LEN_HI:`EEH_CTRL_LEN_LO];
    assign mapped = i_paddr[`EEH_BUF_SEL] || (i_paddr == `EEH_REG_CTRL) || (i_paddr == `EEH_REG_ADDR) ||
                    (i_paddr == `EEH_REG_CFG) || (i_paddr == `EEH_REG_STAT);
    assign o_pready = i_psel && i_penable;
    assign o_pslverr = i_psel && i_penable && !mapped;

    // Read data is captured in the setup cycle so the access phase needs no wait state.
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            if (i_paddr[`EEH_BUF_SEL]) begin
                o_prdata <= {24'h000000, buf_r[i_paddr[6:2]]};
            end else begin
                case (i_paddr)
                    `EEH_REG_CTRL: o_prdata <= {22'h000000, len_r, op_r, 1'b0};
                    `EEH_REG_ADDR: o_prdata <= {16'h0000, addr_r};
                    `EEH_REG_CFG: o_prdata <= {28'h0000000, o_wp, straps_r};
                    `EEH_REG_STAT: o_prdata <= {28'h0000000, timeout_r, nack_r, done_r, o_busy};
                    default: o_prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Configuration registers are held while a command runs.
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            addr_r <= 16'h0000;
            straps_r <= 3'h0;
            o_wp <= 1'b0;
        end else if (bus_wr && (state_r == ST_IDLE)) begin
            if (i_paddr == `EEH_REG_ADDR) begin
                addr_r <= i_pwdata[15:0];
            end
            if (i_paddr == `EEH_REG_CFG) begin
                straps_r <= i_pwdata[2:0];
                o_wp <= i_pwdata[3]; // RULE17
            end
        end
    end

    // Data buffer: software fills it before a write, the engine fills it on a read.
    always @(posedge i_clock) begin
        if (state_r == ST_BIT && tick && q_r == 2'h3 && bit_r == 4'h8 && rx_r) begin
            buf_r[cnt_r[4:0]] <= sh_r;
        end else if (bus_wr && i_paddr[`EEH_BUF_SEL] && (state_r == ST_IDLE)) begin
            buf_r[i_paddr[6:2]] <= i_pwdata[7:0];
        end
    end

    // Programming-cycle watchdog for acknowledge polling.
    always @(posedge i_clock) begin
        if (!i_nrst || !poll_r) begin
            tmr_r <= {`EEH_TMR_W{1'b0}};
        end else if (!tmr_done) begin
            tmr_r <= tmr_r + {{(`EEH_TMR_W-1){1'b0}}, 1'b1};
        end
    end

    // Bit engine: each symbol takes four quarter-periods of the serial clock.
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            state_r <= ST_IDLE;
            step_r <= SQ_DEV;
            q_r <= 2'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h00;
            rx_r <= 1'b0;
            ack_send_r <= 1'b0;
            ack_bit_r <= 1'b1;
            sda_low_r <= 1'b0;
            o_scl <= 1'b1;
            cnt_r <= 6'h00;
            len_r <= 6'h01;
            op_r <= `EEH_OP_WRITE;
            done_r <= 1'b0;
            nack_r <= 1'b0;
            timeout_r <= 1'b0;
            poll_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (go) begin
                        op_r <= i_pwdata[`EEH_CTRL_OP_HI:`EEH_CTRL_OP_LO];
                        // A lock is a single-byte write; other lengths are 1 to one page.
                        if (i_pwdata[`EEH_CTRL_OP_HI:`EEH_CTRL_OP_LO] == `EEH_OP_ID_LOCK || len_req == 6'h00) begin
                            len_r <= 6'h01;
                        end else if (len_req > `EEH_PAGE_BYTES) begin
                            len_r <= `EEH_PAGE_BYTES; // RULE15
                        end else begin
                            len_r <= len_req;
                        end
                        cnt_r <= 6'h00;
                        bit_r <= 4'h0;
                        q_r <= 2'h0;
                        done_r <= 1'b0;
                        nack_r <= 1'b0;
                        timeout_r <= 1'b0;
                        if (i_pwdata[`EEH_CTRL_OP_HI:`EEH_CTRL_OP_LO] == `EEH_OP_RECOVER) begin
                            state_r <= ST_CLK; // RULE7
                            step_r <= SQ_RST;
                        end else begin
                            state_r <= ST_START; // RULE2
                            step_r <= SQ_DEV; // RULE8
                        end
                    end
                end
                ST_NEXT: begin
                    bit_r <= 4'h0;
                    rx_r <= 1'b0;
                    case (step_r)
                        SQ_DEV: begin
                            sh_r <= dev_w | {7'h00, op_r == `EEH_OP_READ_CUR}; // RULE10
                            state_r <= ST_BIT;
                            step_r <= (op_r == `EEH_OP_READ_CUR) ? SQ_RD : SQ_AH;
                        end
                        SQ_AH: begin
                            sh_r <= addr_hi; // RULE12
                            state_r <= ST_BIT;
                            step_r <= SQ_AL;
                        end
                        SQ_AL: begin
                            sh_r <= addr_r[7:0];
                            state_r <= ST_BIT;
                            step_r <= is_wr ? SQ_DATA : SQ_RSTART; // RULE24
                        end
                        SQ_DATA: begin
                            sh_r <= (op_r == `EEH_OP_ID_LOCK) ? (buf_r[0] | `EEH_FREEZE_DATA) : buf_r[cnt_r[4:0]]; // RULE21
                            cnt_r <= cnt_r + 6'h01;
                            state_r <= ST_BIT;
                            step_r <= last ? SQ_STOP : SQ_DATA; // RULE15
                        end
                        SQ_RSTART: begin
                            state_r <= ST_START;
                            step_r <= SQ_DEVR;
                        end
                        SQ_DEVR: begin
                            sh_r <= dev_w | 8'h01;
                            state_r <= ST_BIT;
                            step_r <= SQ_RD;
                        end
                        SQ_RD: begin
                            rx_r <= 1'b1;
                            ack_send_r <= !last; // RULE23
                            state_r <= ST_BIT;
                            step_r <= last ? SQ_STOP : SQ_RD;
                        end
                        SQ_STOP: begin
                            state_r <= ST_STOP; // RULE3
                            // A refused write never programs, so polling would be pointless.
                            if (is_wr && !nack_r) begin
                                poll_r <= 1'b1; // RULE13
                                step_r <= SQ_PSTART;
                            end else begin
                                step_r <= SQ_DONE;
                            end
                        end
                        SQ_PSTART: begin
                            state_r <= ST_START; // RULE20
                            step_r <= SQ_PDEV;
                        end
                        SQ_PDEV: begin
                            sh_r <= dev_w;
                            state_r <= ST_BIT;
                            step_r <= SQ_PEND;
                        end
                        SQ_PEND: begin
                            state_r <= ST_STOP;
                            step_r <= SQ_DONE;
                        end
                        SQ_PSTOP: begin
                            state_r <= ST_STOP;
                            step_r <= SQ_PSTART;
                        end
                        SQ_RST: begin
                            state_r <= ST_START; // RULE7
                            step_r <= SQ_STOP;
                        end
                        default: begin
                            state_r <= ST_IDLE;
                            poll_r <= 1'b0;
                            done_r <= 1'b1;
                        end
                    endcase
                end
                ST_START: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        case (q_r)
                            2'h0: begin
                                o_scl <= 1'b0;
                                sda_low_r <= 1'b0;
                            end
                            2'h1: o_scl <= 1'b1;
                            2'h2: sda_low_r <= 1'b1; // RULE2
                            default: begin
                                o_scl <= 1'b0;
                                state_r <= ST_NEXT;
                            end
                        endcase
                    end
                end
                ST_BIT: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        case (q_r)
                            2'h0: begin
                                o_scl <= 1'b0;
                                if (bit_r == 4'h8) begin
                                    sda_low_r <= rx_r && ack_send_r; // RULE4 RULE23
                                end else begin
                                    sda_low_r <= !rx_r && !sh_r[7]; // RULE1
                                end
                            end
                            2'h1: o_scl <= 1'b1; // RULE5
                            2'h2: begin
                                if (bit_r == 4'h8) begin
                                    ack_bit_r <= sda_s; // RULE4
                                end else begin
                                    sh_r <= {sh_r[6:0], sda_s};
                                end
                            end
                            default: begin
                                o_scl <= 1'b0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == 4'h8) begin
                                    state_r <= ST_NEXT;
                                    if (rx_r) begin
                                        cnt_r <= cnt_r + 6'h01;
                                    end else if (ack_bit_r && step_r == SQ_PEND) begin
                                        // Busy programming: retry until the watchdog expires.
                                        timeout_r <= tmr_done;
                                        step_r <= tmr_done ? SQ_PEND : SQ_PSTOP; // RULE20
                                    end else if (ack_bit_r) begin
                                        // Covers a mismatched address and a locked ID page.
                                        nack_r <= 1'b1; // RULE11 RULE19
                                        step_r <= SQ_STOP;
                                    end
                                end
                            end
                        endcase
                    end
                end
                ST_STOP: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        case (q_r)
                            2'h0: begin
                                o_scl <= 1'b0;
                                sda_low_r <= 1'b1;
                            end
                            2'h1: o_scl <= 1'b1;
                            2'h2: sda_low_r <= 1'b0; // RULE3
                            default: state_r <= ST_NEXT;
                        endcase
                    end
                end
                ST_CLK: begin
                    if (tick) begin
                        q_r <= q_r + 2'h1;
                        case (q_r)
                            2'h0: begin
                                o_scl <= 1'b0;
                                sda_low_r <= 1'b0; // RULE7
                            end
                            2'h1: o_scl <= 1'b1;
                            2'h2: o_scl <= 1'b1;
                            default: begin
                                o_scl <= 1'b0;
                                bit_r <= bit_r + 4'h1;
                                if (bit_r == `EEH_RECOVER_CLOCKS - 4'h1) begin
                                    state_r <= ST_NEXT;
                                end
                            end
                        endcase
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // eeh_host

// >>> eeh_defines.vh
// Constants for the two-wire EEPROM host controller.
`ifndef EEH_DEFINES_VH
`define EEH_DEFINES_VH
`define EEH_REG_CTRL 8'h00
`define EEH_REG_ADDR 8'h04
`define EEH_REG_CFG 8'h08
`define EEH_REG_STAT 8'h0C
`define EEH_BUF_SEL 7
`define EEH_CTRL_GO 0
`define EEH_CTRL_OP_LO 1
`define EEH_CTRL_OP_HI 3
`define EEH_CTRL_LEN_LO 4
`define EEH_CTRL_LEN_HI 9
`define EEH_OP_WRITE 3'h0
`define EEH_OP_READ_RND 3'h1
`define EEH_OP_READ_CUR 3'h2
`define EEH_OP_ID_WRITE 3'h3
`define EEH_OP_ID_READ 3'h4
`define EEH_OP_ID_LOCK 3'h5
`define EEH_OP_RECOVER 3'h6
`define EEH_TYPE_MAIN 4'hA
`define EEH_TYPE_ID 4'hB
`define EEH_IDLOCK_SEL_BIT 2
`define EEH_FREEZE_DATA 8'h02
`define EEH_PAGE_BYTES 6'h20
`define EEH_RECOVER_CLOCKS 4'h9
`define EEH_CLK_KHZ 100000
`define EEH_SCL_KHZ 400
`define EEH_QUARTER_CYC ((`EEH_CLK_KHZ + 4 * `EEH_SCL_KHZ - 1) / (4 * `EEH_SCL_KHZ))
`define EEH_PROG_CYCLE_TIME_US 3000
`define EEH_PROG_CYCLES (`EEH_PROG_CYCLE_TIME_US * (`EEH_CLK_KHZ / 1000))
`define EEH_TMR_W 20
`endif

// >>> eeh_sync.v
// Two flip-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module eeh_sync #(
    parameter W = 1
) (
    input wire i_clock, // System clock.
    input wire i_nrst, // Synchronous reset, active low.
    input wire [W-1:0] i_d, // Asynchronous input.
    output wire [W-1:0] o_q // Synchronised output.
);
    reg [W-1:0] meta_r;
    reg [W-1:0] sync_r;
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            meta_r <= {W{1'b1}};
            sync_r <= {W{1'b1}};
        end else begin
            meta_r <= i_d;
            sync_r <= meta_r;
        end
    end
    assign o_q = sync_r;
endmodule // eeh_sync

// >>> eeh_tick.v
// Divider that gives a one-cycle enable pulse every DIV clocks.
`timescale 1ns/1ps
module eeh_tick #(
    parameter DIV = 63
) (
    input wire i_clock, // System clock.
    input wire i_nrst, // Synchronous reset, active low.
    output reg o_tick // One-cycle enable pulse.
);
    reg [15:0] cnt_r;
    always @(posedge i_clock) begin
        if (!i_nrst) begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b0;
        end else if (cnt_r == DIV[15:0] - 16'h0001) begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule // eeh_tick

// >>> eeh_host_assertions.sv
// Port checker for the two-wire EEPROM host controller.
`timescale 1ns/1ps
module eeh_host_assertions #(parameter QUARTER_CYC = 63, parameter PROG_CYCLES = 300000) (
    input wire i_clock, i_nrst, i_psel, i_penable, i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata, o_prdata,
    input wire o_pready, o_pslverr, o_scl, i_sda, o_sda, o_sda_oe_n, o_wp, o_busy
);
    localparam int QW = 2 * QUARTER_CYC + 2;
    wire acc = i_psel && i_penable;
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    sequence s_start;
        o_scl && $fell(o_sda_oe_n);
    endsequence
    sequence s_scl_low;
        ##[1:QW] !o_scl;
    endsequence
    a_zero_wait: assert property (acc |-> o_pready) else $error("pready missing");
    a_err_unmapped: assert property (o_pslverr |-> acc && !i_paddr[7]
        && !(i_paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})) else $error("pslverr on mapped place");
    a_start_low: assert property (s_start |-> s_scl_low) else $error("clock stuck after start");
    a_stop_hold: assert property (o_scl && $rose(o_sda_oe_n) |=> o_scl [*3]) else $error("stop broken");
    a_bit_stable: assert property ($rose(o_scl) |-> $stable(o_sda_oe_n) [*3]) else $error("data moved");
    a_wp_cfg: assert property (acc && i_pwrite && i_paddr == 8'h08 && !o_busy
        |=> o_wp == $past(i_pwdata[3])) else $error("protect pin wrong");
    a_go_busy: assert property (acc && i_pwrite && i_paddr == 8'h00 && i_pwdata[0] && !o_busy
        |-> ##[1:3] o_busy) else $error("go ignored");
    a_idle_free: assert property (!o_busy [*2] |-> o_scl && o_sda_oe_n) else $error("line held idle");
    a_open_drain: assert property (o_sda == 1'b0) else $error("data drive not low");
endmodule // eeh_host_assertions

// >>> eeh_eeprom_model.sv
// Behavioural two-wire EEPROM that answers the host controller.
`timescale 1ns/1ps
module eeh_eeprom_model #(parameter STRAPS = 3'h5, parameter BUSY_NS = 5000) (
    input wire i_scl, // Serial clock.
    input wire i_sda, // Resolved data line.
    input wire i_wp, // Write-protect pin.
    output reg o_pull_n // Low while pulling data low.
);
    reg [7:0] mem [0:4095];
    reg [7:0] idp [0:31];
    reg [7:0] sh, hi, rb;
    reg [3:0] n = 4'h0;
    reg [2:0] ph = 3'h7;
    reg [11:0] ad = 12'h000;
    reg id = 1'b0, busy = 1'b0, lock = 1'b0, wr = 1'b0;
    initial begin
        o_pull_n = 1'b1;
        for (int i = 0; i < 4096; i++) mem[i] = 8'hFF;
    end
    always @(negedge i_sda) if (i_scl) begin
        ph = 3'h0;
        n = 4'h0;
        wr = 1'b0;
    end
    // Stores land at once; the busy window only models the refusal to answer.
    always @(posedge i_sda) if (i_scl) begin
        ph = 3'h7;
        if (wr && !i_wp) begin
            busy = 1'b1;
            #BUSY_NS busy = 1'b0;
        end
    end
    always @(posedge i_scl) if (ph != 3'h7) begin
        if (ph != 3'h4) sh = {sh[6:0], i_sda};
        n = n + 4'h1;
        if (n == 4'h9 && ph == 3'h4 && i_sda) ph = 3'h7;
    end
    always @(negedge i_scl) begin
        if (n == 4'h9) begin
            n = 4'h0;
            o_pull_n = 1'b1;
            if (ph == 3'h4) begin
                rb = id ? idp[ad[4:0]] : mem[ad];
                ad = ad + 12'h001;
                o_pull_n = rb[7];
            end
        end else if (ph == 3'h4) o_pull_n = (n < 4'h8) ? rb[3'h7 - n[2:0]] : 1'b1;
        else if (n == 4'h8 && ph != 3'h7) begin
            o_pull_n = 1'b0;
            case (ph)
                3'h0: begin
                    id = sh[4];
                    if (sh[7:5] != 3'h5 || sh[3:1] != STRAPS || busy) begin
                        o_pull_n = 1'b1;
                        ph = 3'h7;
                    end else ph = sh[0] ? 3'h4 : 3'h1;
                end
                3'h1: begin hi = sh; ad[11:8] = sh[3:0]; ph = 3'h2; end
                3'h2: begin ad[7:0] = sh; ph = 3'h3; end
                default: begin
                    wr = !(id && lock);
                    if (id && lock) o_pull_n = 1'b1;
                    else if (id && hi[2]) lock = sh[1];
                    else if (id) idp[ad[4:0]] = sh;
                    else if (!i_wp) mem[ad] = sh;
                    ad[4:0] = ad[4:0] + 5'h01;
                end
            endcase
        end
    end
endmodule // eeh_eeprom_model

// >>> eeh_host_tb.sv
// Self-checking bench for the two-wire EEPROM host controller.
`timescale 1ns/1ps
module eeh_host_tb;
    logic i_clock, i_nrst, psel, pen, pwr, pready, perr, scl, sda_oe_n, wp, busy, pull_n, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [47:0] rows [10];
    int num_errors, n_tests, k, r;
    wire sda = sda_oe_n & pull_n;
    eeh_host #(.QUARTER_CYC(4), .PROG_CYCLES(3000)) eeh_host_inst (.i_clock(i_clock), .i_nrst(i_nrst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(perr), .o_scl(scl), .i_sda(sda), .o_sda(), .o_sda_oe_n(sda_oe_n),
        .o_wp(wp), .o_busy(busy));
    eeh_eeprom_model eeh_eeprom_model_inst (.i_scl(scl), .i_sda(sda), .i_wp(wp), .o_pull_n(pull_n));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        pen <= 1'b1;
        k = 0;
        do begin @(posedge i_clock); k++; end while (pready !== 1'b1 && k < 50);
        q = prdata;
        err = perr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (k >= 50) begin num_errors++; conclude; end
    endtask
    // Busy only rises in the update of the go edge, after the bus task has returned, so the wait starts late.
    task wait_idle;
        repeat (3) @(posedge i_clock);
        for (k = 0; busy !== 1'b0 && k < 30000; k++) @(posedge i_clock);
        if (k >= 30000) begin num_errors++; conclude; end
    endtask
    initial begin
        i_nrst = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        n_tests = 0;
        rows = '{48'h05_005E_0041_02,
            48'h05_005E_0023_02, 48'h0D_0100_0001_02,
            48'h04_0000_0011_06, 48'h05_0000_001D_02,
            48'h05_0003_0027_02, 48'h05_0000_001B_02,
            48'h05_0003_0027_06, 48'h05_0003_0029_02, 48'h05_0000_0005_02};
        repeat (20) @(posedge i_clock);
        i_nrst <= 1'b1;
        apb(1'b0, 8'h0C, 32'h0);
        chk("stat", 32'h0, q);
        chk("scl", 32'h1, {31'h0, scl});
        for (r = 0; r < 4; r++) apb(1'b1, 8'(8'h80 + 4 * r), 32'(8'h30 + r));
        for (r = 0; r < 10; r++) begin
            apb(1'b1, 8'h08, {24'h0, rows[r][47:40]});
            apb(1'b1, 8'h04, {16'h0, rows[r][39:24]});
            apb(1'b1, 8'h00, {16'h0, rows[r][23:8]});
            wait_idle;
            apb(1'b0, 8'h0C, 32'h0);
            chk("stat", {24'h0, rows[r][7:0]}, q);
            $display("row %0d done", r);
        end
        for (r = 0; r < 4; r++) chk("page", 32'(8'h30 + r), eeh_eeprom_model_inst.mem[12'h040 | ((30 + r) & 31)]);
        chk("protect", 32'hFF, eeh_eeprom_model_inst.mem[12'h100]);
        chk("idpage", 32'h30, eeh_eeprom_model_inst.idp[3]);
        chk("lock", 32'h1, {31'h0, eeh_eeprom_model_inst.lock});
        apb(1'b0, 8'h84, 32'h0);
        chk("buf", 32'h31, q);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl", 32'h14, q);
        apb(1'b0, 8'h08, 32'h0);
        chk("cfg", 32'h5, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        $display("hand tests done");
        conclude;
    end
endmodule // eeh_host_tb
bind eeh_host eeh_host_assertions #(.QUARTER_CYC(QUARTER_CYC), .PROG_CYCLES(PROG_CYCLES)) eeh_host_assertions_inst (.*);
